// ===== logic/apsc_top.v
// command interpreter with gain-control engine, tone pre-scaler and sync modes
// Functional notes
// - set gain parameter: CF9x word then value, echoed
// - CF8x word returns selected parameter value
// - param_pick_field 0 min gain, Q8, reset 0020
// - param_pick_field 1 max gain, Q8, reset 1000
// - param_pick_field 2 start gain, reset 0800
// - param_pick_field 3 hold in 250us units, reset 1f40
// - param_pick_field 4 attack index, reset 5
// - param_pick_field 5 decay index, reset 000d
// - param_pick_field 6 threshold, reset 2000, triggers attack
// - param_pick_field 7 enable, reset off
// - index n means right shift by n+1
// - attack subtracts (gain-min) shifted per sample
// - decay adds (max-gain) shifted per sample
// - CF05 returns pre-scaler, reset 0040
// - CF07 then value sets pre-scaler, echoed
// - pre-scaler linear, 0040 is unity
// - pre-scaler only on tone detector path
// - 5100-5103 pick record sync mode, echoed
// - 5200-5203 pick playback sync mode, echoed
// - record and playback sync held separately
// - both channels codec sync after reset
// - hold counter after attack, then decay
// - Q8 product then 8-bit arithmetic shift
//
// Chosen here: the Avalon-MM slave port and the address map.
`include "apsc_defs.vh"
`default_nettype none

module apsc_top (
	input  wire        clock,          // 50 MHz system clock
	input  wire        rst_b,          // asynchronous reset, active low
	input  wire [3:0]  address,        // avalon byte address
	input  wire        read,           // avalon read request
	input  wire        write,          // avalon write request
	input  wire [31:0] writedata,      // avalon write data
	output reg  [31:0] readdata,       // avalon read data
	output wire        waitrequest,    // avalon stall
	input  wire        sampleStrobe,   // one pulse per codec sample
	input  wire [15:0] recordIn,       // signed record sample into gain control
	input  wire [15:0] toneIn,         // signed sample into tone detector path
	output reg  [15:0] recordOut,      // gain-controlled record sample
	output reg  [15:0] toneOut,        // pre-scaled sample to tone detectors
	output reg         sampleValid,    // pulse when outputs updated
	output reg  [1:0]  recordSync,     // record channel sync mode
	output reg  [1:0]  playbackSync,   // playback channel sync mode
	output reg  [15:0] gainNow         // current gain, Q8
);

	reg        ack_q;                  // second cycle of a bus access
	reg [15:0] param_q [0:7];          // gain-control parameters
	reg [15:0] preScale_q;             // tone pre-scaler, Q6
	reg [15:0] status_q;               // last status word
	reg        statusValid_q;          // status not yet read
	reg        expectValue_q;          // next command is a value word
	reg        valueForPre_q;          // pending value goes to pre-scaler
	reg [2:0]  pendSel_q;              // pending parameter param_pick_field
	reg [1:0]  phase_q;                // attack, hold or decay
	reg [16:0] holdCnt_q;              // hold samples remaining
	reg        agcOnPrev_q;            // enable seen last sample

	wire        agcOn    = param_q[`APSC_SEL_ENABLE][0];
	wire [15:0] minGain  = param_q[`APSC_SEL_MIN];
	wire [15:0] maxGain  = param_q[`APSC_SEL_MAX];
	wire [3:0]  atkIdx   = param_q[`APSC_SEL_ATTACK][3:0];
	wire [3:0]  decIdx   = param_q[`APSC_SEL_DECAY][3:0];
	wire [15:0] thresh   = param_q[`APSC_SEL_THRESH] & `APSC_THRESH_MASK;
	wire [15:0] cmdWord  = writedata[15:0];
	wire        cmdWr    = write && ack_q && (address == `APSC_OFS_CMD);
	wire        statRd   = read && ack_q && (address == `APSC_OFS_STATUS);

	// every access stalls one cycle, then completes
	assign waitrequest = (read || write) && !ack_q;

	// bus acknowledge toggle
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (read || write) && !ack_q;
		end
	end

	// read data prepared in the stall cycle, held for the answer cycle
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			readdata <= 32'h00000000;
		end else if (read && !ack_q) begin
			case (address)
				`APSC_OFS_STATUS: readdata <= {16'h0000, status_q};
				`APSC_OFS_FLAGS:  readdata <= {23'h000000, phase_q, agcOn, playbackSync,
				                               recordSync, expectValue_q, statusValid_q};
				default:          readdata <= 32'h00000000; // command and unmapped read zero
			endcase
		end
	end

	// command interpreter
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			param_q[`APSC_SEL_MIN]    <= `APSC_RST_MIN;
			param_q[`APSC_SEL_MAX]    <= `APSC_RST_MAX;
			param_q[`APSC_SEL_START]  <= `APSC_RST_START;
			param_q[`APSC_SEL_HOLD]   <= `APSC_RST_HOLD;
			param_q[`APSC_SEL_ATTACK] <= `APSC_RST_ATTACK;
			param_q[`APSC_SEL_DECAY]  <= `APSC_RST_DECAY;
			param_q[`APSC_SEL_THRESH] <= `APSC_RST_THRESH;
			param_q[`APSC_SEL_ENABLE] <= `APSC_RST_ENABLE;
			preScale_q    <= `APSC_RST_PRESCALE;
			status_q      <= 16'h0000;
			statusValid_q <= 1'b0;
			expectValue_q <= 1'b0;
			valueForPre_q <= 1'b0;
			pendSel_q     <= 3'h0;
			recordSync    <= `APSC_SYNC_CODEC;
			playbackSync  <= `APSC_SYNC_CODEC;
		end else begin
			// a new status beats the clear from a read
			if (statRd) begin
				statusValid_q <= 1'b0;
			end
			if (cmdWr) begin
				statusValid_q <= 1'b1;
				status_q      <= cmdWord; // echo unless replaced below
				if (expectValue_q) begin
					// value word lands only now
					expectValue_q <= 1'b0;
					if (valueForPre_q) begin
						preScale_q <= cmdWord;
					end else begin
						param_q[pendSel_q] <= cmdWord;
					end
				end else if (cmdWord[15:3] == `APSC_SET_PREFIX) begin
					expectValue_q <= 1'b1;
					valueForPre_q <= 1'b0;
					pendSel_q     <= cmdWord[2:0];
				end else if (cmdWord[15:3] == `APSC_GET_PREFIX) begin
					status_q <= param_q[cmdWord[2:0]];
				end else if (cmdWord == `APSC_CMD_PRE_READ) begin
					status_q <= preScale_q;
				end else if (cmdWord == `APSC_CMD_PRE_WRITE) begin
					expectValue_q <= 1'b1;
					valueForPre_q <= 1'b1;
				end else if (cmdWord[15:2] == `APSC_REC_SYNC_BASE) begin
					recordSync <= cmdWord[1:0];
				end else if (cmdWord[15:2] == `APSC_PB_SYNC_BASE) begin
					playbackSync <= cmdWord[1:0];
				end
			end
		end
	end

	// sample arithmetic
	wire signed [32:0] recProd  = $signed(recordIn) * $signed({1'b0, gainNow});
	wire signed [32:0] recScale = recProd >>> `APSC_GAIN_FRAC;
	wire signed [32:0] preProd  = $signed(toneIn) * $signed({1'b0, preScale_q});
	wire signed [32:0] preScale = preProd >>> `APSC_PRE_FRAC;
	wire [15:0] agcSample = agcOn ? recScale[15:0] : recordIn;
	wire [15:0] magnitude = agcSample[15] ? (16'h0000 - agcSample) : agcSample;
	wire        overThr   = magnitude > thresh;
	wire [15:0] atkStep   = (gainNow > minGain) ? ((gainNow - minGain) >> ({1'b0, atkIdx} + 5'd1)) : 16'h0000;
	wire [15:0] decStep   = (maxGain > gainNow) ? ((maxGain - gainNow) >> ({1'b0, decIdx} + 5'd1)) : 16'h0000;
	wire [31:0] holdWide  = {16'h0000, param_q[`APSC_SEL_HOLD]} * `APSC_HOLD_SAMPLES;
	wire [16:0] holdLoad  = holdWide[16:0];                                        // hold in samples fits 17 bits

	// per-sample gain engine and output registers
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gainNow     <= `APSC_RST_START;
			phase_q     <= `APSC_PH_DECAY;
			holdCnt_q   <= 17'h00000;
			agcOnPrev_q <= 1'b0;
			recordOut   <= 16'h0000;
			toneOut     <= 16'h0000;
			sampleValid <= 1'b0;
		end else begin
			sampleValid <= sampleStrobe;
			if (sampleStrobe) begin
				agcOnPrev_q <= agcOn;
				recordOut   <= agcSample;
				toneOut     <= preScale[15:0]; // tone path only, volume untouched
				if (agcOn && !agcOnPrev_q) begin
					gainNow <= param_q[`APSC_SEL_START];
					phase_q <= `APSC_PH_DECAY;
				end else if (agcOn) begin
					if (overThr) begin
						phase_q <= `APSC_PH_ATTACK;
						gainNow <= gainNow - atkStep;
					end else begin
						case (phase_q)
							`APSC_PH_ATTACK: begin
								phase_q   <= `APSC_PH_HOLD;
								holdCnt_q <= holdLoad;
							end
							`APSC_PH_HOLD: begin
								if (holdCnt_q == 17'h00000) begin
									phase_q <= `APSC_PH_DECAY;
								end else begin
									holdCnt_q <= holdCnt_q - 17'h00001;
								end
							end
							default: begin
								gainNow <= gainNow + decStep;
							end
						endcase
					end
				end
			end
		end
	end

endmodule

`default_nettype wire

// ===== logic/apsc_defs.vh
// constants for the gain-control, pre-scaler and sync-mode command block
`ifndef APSC_DEFS_VH
`define APSC_DEFS_VH

// bus register byte offsets
`define APSC_OFS_CMD        4'h0
`define APSC_OFS_STATUS     4'h4
`define APSC_OFS_FLAGS      4'h8

// command word patterns
`define APSC_SET_PREFIX     13'h19f2
`define APSC_GET_PREFIX     13'h19f0
`define APSC_CMD_PRE_READ   16'hcf05
`define APSC_CMD_PRE_WRITE  16'hcf07
`define APSC_REC_SYNC_BASE  14'h1440
`define APSC_PB_SYNC_BASE   14'h1480

// parameter selectors
`define APSC_SEL_MIN        3'h0
`define APSC_SEL_MAX        3'h1
`define APSC_SEL_START      3'h2
`define APSC_SEL_HOLD       3'h3
`define APSC_SEL_ATTACK     3'h4
`define APSC_SEL_DECAY      3'h5
`define APSC_SEL_THRESH     3'h6
`define APSC_SEL_ENABLE     3'h7

// reset values
`define APSC_RST_MIN        16'h0020
`define APSC_RST_MAX        16'h1000
`define APSC_RST_START      16'h0800
`define APSC_RST_HOLD       16'h1f40
`define APSC_RST_ATTACK     16'h0005
`define APSC_RST_DECAY      16'h000d
`define APSC_RST_THRESH     16'h2000
`define APSC_RST_ENABLE     16'h0000
`define APSC_RST_PRESCALE   16'h0040
`define APSC_THRESH_MASK    16'h7fff

// sync modes
`define APSC_SYNC_CODEC     2'h0
`define APSC_SYNC_DATA      2'h1
`define APSC_SYNC_POLL      2'h2
`define APSC_SYNC_HOST      2'h3

// fixed-point shifts and timing
`define APSC_GAIN_FRAC      8
`define APSC_PRE_FRAC       6
`define APSC_HOLD_UNIT_US   250
`define APSC_SAMPLE_US      125
`define APSC_HOLD_SAMPLES   (`APSC_HOLD_UNIT_US / `APSC_SAMPLE_US)

// gain phases
`define APSC_PH_ATTACK      2'h0
`define APSC_PH_HOLD        2'h1
`define APSC_PH_DECAY       2'h2

`endif

// ===== sim/apsc_chk.sv
// port assertions for the command block
`default_nettype none
module apsc_chk (
	input wire logic        clock,        // clock
	input wire logic        rst_b,        // reset, active low
	input wire logic [3:0]  address,      // byte address
	input wire logic        read,         // read request
	input wire logic        write,        // write request
	input wire logic [31:0] writedata,    // write data
	input wire logic        waitrequest,  // stall
	input wire logic        sampleStrobe, // sample pulse
	input wire logic        sampleValid,  // output pulse
	input wire logic [1:0]  recordSync,   // record sync mode
	input wire logic [1:0]  playbackSync, // playback sync mode
	input wire logic [15:0] gainNow       // current gain
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// command word committed at this edge
	wire cmdWr = write && !waitrequest && address == 4'h0;
	wire recCmd = cmdWr && writedata[15:2] == 14'h1440; // record sync word
	wire pbCmd = cmdWr && writedata[15:2] == 14'h1480;  // playback sync word
	sync_rst_a: assert property ($rose(rst_b) |-> recordSync == 2'h0 && playbackSync == 2'h0)
		else $error("sync not codec after reset");
	gain_rst_a: assert property ($rose(rst_b) |-> gainNow == 16'h0800)
		else $error("gain not start value after reset");
	rec_sync_a: assert property (recCmd |=> recordSync == $past(writedata[1:0]))
		else $error("record sync not taken");
	pb_sync_a: assert property (pbCmd |=> playbackSync == $past(writedata[1:0]))
		else $error("playback sync not taken");
	sync_sep_a: assert property (recCmd |=> $stable(playbackSync))
		else $error("playback sync moved");
	bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer next cycle");
	valid_pulse_a: assert property (sampleStrobe |=> sampleValid)
		else $error("no valid after strobe");
	valid_quiet_a: assert property (!sampleStrobe |=> !sampleValid)
		else $error("valid without strobe");
	gain_still_a: assert property (!sampleStrobe |=> $stable(gainNow))
		else $error("gain moved between samples");
	cover property (recCmd);
	cover property (pbCmd);
	cover property (sampleValid && gainNow != 16'h0800);
endmodule
bind apsc_top apsc_chk apsc_chk_inst (.clock, .rst_b, .address, .read, .write, .writedata, .waitrequest,
	.sampleStrobe, .sampleValid, .recordSync, .playbackSync, .gainNow);
`default_nettype wire

// ===== sim/apsc_host.sv
// host processor model: avalon master issuing command and status cycles
`default_nettype none
module apsc_host (
	input  wire logic        clock,      // clock
	output var  logic [3:0]  address,    // byte address
	output var  logic        read,       // read request
	output var  logic        write,      // write request
	output var  logic [31:0] writedata,  // write data
	input  wire logic [31:0] readdata,   // read data
	input  wire logic        waitrequest // stall
);
	timeunit 1ns;
	timeprecision 1ns;
	// bus idle from time zero
	initial begin
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0000_0000;
	end
	// one access; request held until a rising edge samples waitrequest low, released at that edge
	task automatic xfer(input logic wr, input logic [3:0] adr, input logic [15:0] wd,
		output logic [15:0] rd, output logic ok);
		int n;
		n = 0;
		@(posedge clock);
		address <= adr;
		writedata <= {16'h0000, wd};
		read <= !wr;
		write <= wr;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		rd = readdata[15:0];
		ok = (waitrequest === 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== sim/apsc_top_tb_top.sv
// self-checking bench for the command block
`default_nettype none
module apsc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0;        // 50 MHz
	logic        rst_b = 1'b0;        // reset, active low
	logic        sampleStrobe = 1'b0; // sample pulse
	logic [15:0] recordIn = 16'h0000; // record sample
	logic [15:0] toneIn = 16'h0000;   // tone sample
	logic [3:0]  address;             // bus from host
	logic        read, write, waitrequest, sampleValid;
	logic [31:0] writedata, readdata;
	logic [15:0] recordOut, toneOut, gainNow, rd;
	logic [1:0]  recordSync, playbackSync;
	int          num_errors = 0;
	int          checks = 0;
	// command rows; sync rows past the ninth expect an echo
	logic [15:0] rowCmd[17] = '{16'hcf80, 16'hcf81, 16'hcf82, 16'hcf83, 16'hcf84, 16'hcf85, 16'hcf86, 16'hcf87,
		16'hcf05, 16'h5200, 16'h5201, 16'h5202, 16'h5203, 16'h5100, 16'h5101, 16'h5102, 16'h5103};
	logic [15:0] rowStat[9] = '{16'h0020, 16'h1000, 16'h0800, 16'h1f40, 16'h0005, 16'h000d, 16'h2000,
		16'h0000, 16'h0040};
	always #10 clock = ~clock;
	apsc_top apsc_top_inst (.clock, .rst_b, .address, .read, .write, .writedata, .readdata, .waitrequest,
		.sampleStrobe, .recordIn, .toneIn, .recordOut, .toneOut, .sampleValid, .recordSync, .playbackSync,
		.gainNow);
	apsc_host apsc_host_inst (.clock, .address, .read, .write, .writedata, .readdata, .waitrequest);
	// print counts and verdict, then stop
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// a hung bus ends the run
	task automatic bus(input logic wr, input logic [3:0] adr, input logic [15:0] wd);
		logic ok;
		apsc_host_inst.xfer(wr, adr, wd, rd, ok);
		if (!ok) begin
			num_errors++;
			$display("mismatch at %0t: bus hung", $time);
			wrap_up();
		end
	endtask
	// command write, then status read into rd
	task automatic cmd(input logic [15:0] w);
		bus(1'b1, 4'h0, w);
		bus(1'b0, 4'h4, 16'h0000);
	endtask
	// set word and value word always sent as a pair
	task automatic set(input logic [2:0] s, input logic [15:0] v);
		cmd({13'h19f2, s});
		chk(rd, {13'h19f2, s}, "set echo");
		cmd(v);
		chk(rd, v, "value echo");
		cmd({13'h19f0, s});
		chk(rd, v, "readback");
	endtask
	// one codec sample; outputs land on the edge after the strobe
	task automatic samp(input logic [15:0] r, input logic [15:0] t);
		@(posedge clock);
		sampleStrobe <= 1'b1;
		recordIn <= r;
		toneIn <= t;
		@(posedge clock);
		sampleStrobe <= 1'b0;
		@(negedge clock);
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		// sync commands issued with no channel running
		for (int i = 0; i < 17; i++) begin
			cmd(rowCmd[i]);
			chk(rd, i < 9 ? rowStat[i] : rowCmd[i], "status");
		end
		chk({12'h000, recordSync, playbackSync}, 16'h000f, "sync host");
		bus(1'b0, 4'hc, 16'h0000);
		chk(rd, 16'h0000, "unmapped");
		$display("table test done");
		samp(16'h0000, 16'h1000);
		chk(toneOut, 16'h1000, "unity");
		cmd(16'hcf07);
		chk(rd, 16'hcf07, "pre echo");
		cmd(16'h0020);
		chk(rd, 16'h0020, "pre value");
		cmd(16'hcf05);
		chk(rd, 16'h0020, "pre read");
		samp(16'h1234, 16'h1000);
		chk(toneOut, 16'h0800, "half");
		chk(recordOut, 16'h1234, "record bypass");
		$display("prescale test done");
		set(3'h1, 16'h0800);
		set(3'h3, 16'h0001);
		set(3'h5, 16'h0000);
		set(3'h7, 16'h0001);
		samp(16'h0000, 16'h0000);
		chk(gainNow, 16'h0800, "start gain");
		samp(16'h0800, 16'h0000);
		chk(recordOut, 16'h4000, "scaled");
		chk(gainNow, 16'h07e1, "attack");
		repeat (2) begin
			samp(16'h0000, 16'h0000);
			chk(gainNow, 16'h07e1, "hold");
		end
		for (int k = 0; k < 4 && gainNow === 16'h07e1; k++) samp(16'h0000, 16'h0000);
		chk(gainNow, 16'h07f0, "decay");
		$display("gain test done");
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		@(negedge clock);
		chk({12'h000, recordSync, playbackSync}, 16'h0000, "sync reset");
		chk(gainNow, 16'h0800, "gain reset");
		cmd(16'hcf81);
		chk(rd, 16'h1000, "max reset");
		$display("reset test done");
		wrap_up();
	end
endmodule
`default_nettype wire
